// ---- core/vsc_pkg.sv ----
// Shared constants and types for the recording session link
package vsc_pkg;
  localparam int SYS_PERIOD_NS    = 50;
  localparam int LINK_PERIOD_NS   = 400;
  localparam int LINK_HALF_CYCLES = LINK_PERIOD_NS / (2 * SYS_PERIOD_NS);
  localparam logic [2:0] LINK_HALF_LAST = 3'(LINK_HALF_CYCLES - 1);

  localparam int BLOCK_BYTES  = 512;
  localparam int CHUNK_BYTES  = 512 * 1024;
  localparam int CHUNK_BLOCKS = CHUNK_BYTES / BLOCK_BYTES;
  localparam int CHUNK_LSB    = $clog2(CHUNK_BLOCKS);
  localparam int AU_BLOCKS    = 8192;
  localparam int AU_LSB       = $clog2(AU_BLOCKS);
  localparam logic [3:0] AU_MAX = 4'h8;

  // Command indices
  localparam logic [5:0] IDX_SESSION   = 6'h14;
  localparam logic [5:0] IDX_WR_SINGLE = 6'h18;
  localparam logic [5:0] IDX_WR_MULTI  = 6'h19;
  localparam logic [5:0] IDX_WR_EXT_LO = 6'h22;
  localparam logic [5:0] IDX_WR_EXT_HI = 6'h25;
  localparam logic [5:0] IDX_WR_50     = 6'h32;
  localparam logic [5:0] IDX_WR_57     = 6'h39;

  // Session function field in the argument
  localparam int FN_LSB   = 0;
  localparam int SLOT_LSB = 4;
  localparam logic [3:0] FN_START_REC   = 4'h0;
  localparam logic [3:0] FN_UPDATE_DIR  = 4'h1;
  localparam logic [3:0] FN_UPDATE_CI   = 4'h2;
  localparam logic [3:0] FN_SUSPEND     = 4'h3;
  localparam logic [3:0] FN_RESUME      = 4'h4;
  localparam logic [3:0] FN_SET_FREE    = 4'h5;
  localparam logic [3:0] FN_RELEASE_DIR = 4'h6;

  // Terminating command sets, one bit per index
  localparam logic [63:0] TERM_CMD_BASE  = 64'h0000fe80_fc41cfff;
  localparam logic [63:0] TERM_CMD_51_56 = 64'h01080000_00000000;
  localparam logic [63:0] TERM_CMD_60_63 = 64'hf0000000_00000000;
  localparam logic [63:0] TERM_ACMD_LOW  = 64'h00000000_003a1ffe;
  localparam logic [63:0] TERM_ACMD_MID  = 64'h0000003f_e9000000;
  localparam logic [63:0] TERM_ACMD_HIGH = 64'hff740780_00000000;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SEND} host_state_t;
endpackage : vsc_pkg

// ---- core/vsc_link_if.sv ----
// Command link between host controller and card tracker
interface vsc_link_if;
  logic        lclk;
  logic        strobe;
  logic        app;
  logic [5:0]  index;
  logic [31:0] arg;
  logic [15:0] len;

  modport host_end (output lclk, output strobe, output app, output index, output arg, output len);
  modport card_end (input lclk, input strobe, input app, input index, input arg, input len);
endinterface : vsc_link_if

// ---- core/link_sync.sv ----
// Three-stage input synchroniser with agreement filter
module link_sync #(
  parameter int WIDTH = 57
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          sync_out[i] <= 1'b0;
        end else if (s2_reg[i] == s3_reg[i]) begin
          sync_out[i] <= s3_reg[i];
        end
      end
    end
  endgenerate
endmodule : link_sync

// ---- core/vsc_card_end.sv ----
// Card-side recording session tracker
// Operation
// RULE_01 - Misfit or misaligned CMD50 breaks subunit timing
// RULE_02 - Any CMD51 or CMD56 ends recording
// RULE_03 - CMD57 nonsequential ends; misfit breaks timing
// RULE_04 - Commands 60 to 63 end recording
// RULE_05 - App commands 1-12, 17, 19-21 end recording
// RULE_06 - App commands 24, 27, 29-37 end recording
// RULE_07 - App commands 39-42, 50, 52-54, 56-63 end
// RULE_08 - Suspend between chunks frees slots, unused blocks
// RULE_09 - Resume address: next chunk if active, else zero
// RULE_10 - Suspend mid-chunk frees all, zero resume address
// RULE_11 - Suspend without active block keeps resume address
// RULE_12 - Host resumes: update dir, resume, start recording
// RULE_13 - Zero resume address: host starts fresh session
// RULE_14 - Write into suspended block clears resume address
// RULE_15 - Eight directory slots, assigned and released
// RULE_16 - Host writes whole chunks, pads partial ones
// RULE_17 - Directory and info updates keep recording
// RULE_18 - Multi writes across subunits keep performance
// RULE_19 - Writes across assigned blocks keep performance
// RULE_20 - Writes past active blocks may drop performance
// RULE_21 - Saved write position survives power cycle
// RULE_22 - Recording chunk fixed at 512KB
// RULE_23 - Terminating command frees blocks, ends recording
// RULE_24 - Next expected address detects nonsequential writes
module vsc_card_end (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  vsc_link_if.card_end     link,
  input  wire logic [31:0] saved_resume_address,
  output logic             recording,
  output logic             su_timing_broken,
  output logic             perf_dropped,
  output logic             suspended,
  output logic [31:0]      resume_address,
  output logic [7:0]       dir_slots,
  output logic [3:0]       au_assigned
);
  logic [56:0] link_raw;
  logic [56:0] link_s;
  logic        lclk_prev_reg;
  logic        loaded_reg,    loaded_next;
  logic        rec_reg,       rec_next;
  logic        sub_reg,       sub_next;
  logic        drop_reg,      drop_next;
  logic        susp_reg,      susp_next;
  logic [31:0] susp_base_reg, susp_base_next;
  logic [31:0] resume_reg,    resume_next;
  logic [7:0]  slots_reg,     slots_next;
  logic [31:0] au_base_reg,   au_base_next;
  logic [3:0]  au_cnt_reg,    au_cnt_next;
  logic [31:0] next_addr_reg, next_addr_next;

  assign link_raw = {link.lclk, link.strobe, link.app, link.index, link.arg, link.len};

  link_sync #(.WIDTH(57)) u_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in (link_raw),
    .sync_out (link_s)
  );

  wire        lclk_s   = link_s[56];
  wire        strobe_s = link_s[55];
  wire        app_s    = link_s[54];
  wire [5:0]  idx_s    = link_s[53:48];
  wire [31:0] arg_s    = link_s[47:16];
  wire [15:0] len_s    = link_s[15:0];
  wire        take     = lclk_s & ~lclk_prev_reg & strobe_s;

  wire [3:0]  fn       = arg_s[vsc_pkg::FN_LSB +: 4];
  wire [2:0]  slot     = arg_s[vsc_pkg::SLOT_LSB +: 3];
  wire        is_sess  = !app_s && (idx_s == vsc_pkg::IDX_SESSION);
  wire        is_wr1   = !app_s && (idx_s == vsc_pkg::IDX_WR_SINGLE);
  wire        is_wrext = !app_s && (idx_s >= vsc_pkg::IDX_WR_EXT_LO) && (idx_s <= vsc_pkg::IDX_WR_EXT_HI);
  wire        is_wrn   = !app_s && ((idx_s == vsc_pkg::IDX_WR_MULTI) || is_wrext ||
                                    (idx_s == vsc_pkg::IDX_WR_50) || (idx_s == vsc_pkg::IDX_WR_57));
  wire        is_write = is_wr1 | is_wrn;
  wire [15:0] wr_len   = is_wr1 ? 16'h0001 : len_s;

  wire [63:0] idx_bit  = 64'h1 << idx_s;
  wire        t_cmd    = !app_s && ((idx_bit & vsc_pkg::TERM_CMD_BASE) != 64'h0);
  wire        t_51_56  = !app_s && ((idx_bit & vsc_pkg::TERM_CMD_51_56) != 64'h0); // RULE_02
  wire        t_60_63  = !app_s && ((idx_bit & vsc_pkg::TERM_CMD_60_63) != 64'h0); // RULE_04
  wire        t_a_low  = app_s && ((idx_bit & vsc_pkg::TERM_ACMD_LOW) != 64'h0); // RULE_05
  wire        t_a_mid  = app_s && ((idx_bit & vsc_pkg::TERM_ACMD_MID) != 64'h0); // RULE_06
  wire        t_a_high = app_s && ((idx_bit & vsc_pkg::TERM_ACMD_HIGH) != 64'h0); // RULE_07

  // Active window and write geometry
  wire [31:0] au_span  = {15'h0, au_cnt_reg, 13'h0};
  wire [31:0] au_end   = au_base_reg + au_span;
  wire [31:0] wr_end   = arg_s + {16'h0, wr_len};
  wire [31:0] wr_used  = wr_end - au_base_reg;
  wire [18:0] au_done  = wr_used[31:vsc_pkg::AU_LSB];
  wire        in_act   = (au_cnt_reg != 4'h0) && (arg_s >= au_base_reg) && (arg_s < au_end);
  wire        seq_bad  = is_write && in_act && (arg_s != next_addr_reg); // RULE_24 RULE_03
  wire        chunk_bad = is_wr1 || (wr_len[vsc_pkg::CHUNK_LSB-1:0] != '0) ||
                          (arg_s[vsc_pkg::CHUNK_LSB-1:0] != '0); // RULE_22
  wire        past_end = wr_end > au_end; // RULE_20
  wire [31:0] in_susp_off = arg_s - susp_base_reg;
  wire        in_susp  = susp_reg && (arg_s >= susp_base_reg) &&
                         (in_susp_off[31:vsc_pkg::AU_LSB] == 19'h0);
  wire        terminate = t_cmd | t_51_56 | t_60_63 | t_a_low | t_a_mid | t_a_high | seq_bad;
  wire        mid_chunk = next_addr_reg[vsc_pkg::CHUNK_LSB-1:0] != '0;
  wire        next_act  = next_addr_reg < au_end;

  always_comb begin
    loaded_next    = 1'b1;
    rec_next       = rec_reg;
    sub_next       = sub_reg;
    drop_next      = drop_reg;
    susp_next      = susp_reg;
    susp_base_next = susp_base_reg;
    resume_next    = resume_reg;
    slots_next     = slots_reg;
    au_base_next   = au_base_reg;
    au_cnt_next    = au_cnt_reg;
    next_addr_next = next_addr_reg;
    if (!loaded_reg) begin
      resume_next    = saved_resume_address; // RULE_21
      susp_next      = saved_resume_address != 32'h0;
      susp_base_next = {saved_resume_address[31:vsc_pkg::AU_LSB], 13'h0};
    end else if (take) begin
      if (is_write && in_susp) begin
        resume_next = 32'h0; // RULE_14
        susp_next   = 1'b0;
      end
      if (terminate) begin
        rec_next    = 1'b0; // RULE_23
        au_cnt_next = 4'h0;
        slots_next  = 8'h00;
      end else if (is_sess) begin
        case (fn)
          vsc_pkg::FN_START_REC: begin
            rec_next  = 1'b1;
            sub_next  = 1'b0;
            drop_next = 1'b0;
          end
          vsc_pkg::FN_SET_FREE: begin
            au_base_next   = {arg_s[31:vsc_pkg::AU_LSB], 13'h0};
            next_addr_next = {arg_s[31:vsc_pkg::AU_LSB], 13'h0};
            au_cnt_next    = {1'b0, slot} + 4'h1;
          end
          vsc_pkg::FN_UPDATE_DIR: begin
            slots_next[slot] = 1'b1; // RULE_15 RULE_17
          end
          vsc_pkg::FN_RELEASE_DIR: begin
            slots_next[slot] = 1'b0; // RULE_15 RULE_17
          end
          vsc_pkg::FN_SUSPEND: begin
            if (au_cnt_reg != 4'h0) begin // RULE_11
              rec_next    = 1'b0;
              slots_next  = 8'h00; // RULE_08 RULE_10
              au_cnt_next = 4'h0;
              if (!mid_chunk && next_act) begin
                resume_next    = next_addr_reg; // RULE_09
                susp_next      = 1'b1;
                susp_base_next = {next_addr_reg[31:vsc_pkg::AU_LSB], 13'h0};
              end else begin
                resume_next = 32'h0; // RULE_09 RULE_10
                susp_next   = 1'b0;
              end
            end
          end
          vsc_pkg::FN_RESUME: begin
            if (susp_reg && (resume_reg != 32'h0)) begin
              au_base_next   = susp_base_reg; // RULE_12
              au_cnt_next    = 4'h1;
              next_addr_next = resume_reg;
              susp_next      = 1'b0;
            end
          end
          default: begin
          end
        endcase
      end else if (is_write && in_act) begin
        if (chunk_bad) begin
          sub_next = 1'b1; // RULE_01 RULE_03
        end
        if (past_end) begin
          drop_next = 1'b1; // RULE_20
        end
        next_addr_next = wr_end; // RULE_24
        if (au_done >= {15'h0, au_cnt_reg}) begin
          au_cnt_next = 4'h0;
        end else begin
          au_base_next = au_base_reg + {au_done, 13'h0}; // RULE_18 RULE_19
          au_cnt_next  = au_cnt_reg - au_done[3:0];
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lclk_prev_reg <= 1'b0;
      loaded_reg    <= 1'b0;
      rec_reg       <= 1'b0;
      sub_reg       <= 1'b0;
      drop_reg      <= 1'b0;
      susp_reg      <= 1'b0;
      susp_base_reg <= 32'h0;
      resume_reg    <= 32'h0;
      slots_reg     <= 8'h00;
      au_base_reg   <= 32'h0;
      au_cnt_reg    <= 4'h0;
      next_addr_reg <= 32'h0;
    end else begin
      lclk_prev_reg <= lclk_s;
      loaded_reg    <= loaded_next;
      rec_reg       <= rec_next;
      sub_reg       <= sub_next;
      drop_reg      <= drop_next;
      susp_reg      <= susp_next;
      susp_base_reg <= susp_base_next;
      resume_reg    <= resume_next;
      slots_reg     <= slots_next;
      au_base_reg   <= au_base_next;
      au_cnt_reg    <= au_cnt_next;
      next_addr_reg <= next_addr_next;
    end
  end

  assign recording        = rec_reg;
  assign su_timing_broken = sub_reg;
  assign perf_dropped     = drop_reg;
  assign suspended        = susp_reg;
  assign resume_address   = resume_reg;
  assign dir_slots        = slots_reg;
  assign au_assigned      = au_cnt_reg;
endmodule : vsc_card_end

// ---- core/vsc_host_end.sv ----
// Host-side command sender with link clock divider
module vsc_host_end (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  vsc_link_if.host_end     link,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic        req_app,
  input  wire logic [5:0]  req_index,
  input  wire logic [31:0] req_arg,
  input  wire logic [15:0] req_len,
  input  wire logic        resume_address_zero,
  output logic             req_refused
);
  vsc_pkg::host_state_t state_reg, state_next;
  logic [2:0]  div_reg;
  logic        lclk_reg;
  logic        strobe_reg;
  logic        app_reg;
  logic [5:0]  idx_reg;
  logic [31:0] arg_reg;
  logic [15:0] len_reg;
  logic        refused_reg;
  logic        dir_ok_reg;
  logic        resumed_reg;
  logic        rec_reg;

  wire       div_wrap = div_reg == vsc_pkg::LINK_HALF_LAST;
  wire       fall     = lclk_reg & div_wrap;
  wire       accept   = (state_reg == vsc_pkg::ST_IDLE) & req_valid;
  wire       sess     = !req_app && (req_index == vsc_pkg::IDX_SESSION);
  wire [3:0] fn       = req_arg[vsc_pkg::FN_LSB +: 4];
  wire       is_wr    = !req_app && ((req_index == vsc_pkg::IDX_WR_SINGLE) ||
                                     (req_index == vsc_pkg::IDX_WR_MULTI));
  wire       bad_res  = sess && (fn == vsc_pkg::FN_RESUME) &&
                        (!dir_ok_reg || resume_address_zero); // RULE_12 RULE_13
  wire       bad_wr   = is_wr && resumed_reg; // RULE_12
  wire       refuse   = bad_res | bad_wr;
  wire       pad      = rec_reg && !req_app && (req_index == vsc_pkg::IDX_WR_MULTI) &&
                        (req_len[vsc_pkg::CHUNK_LSB-1:0] != '0);
  wire [15:0] len_pad = pad ? {req_len[15:10] + 6'h01, 10'h000} : req_len; // RULE_16

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      vsc_pkg::ST_IDLE: begin
        if (accept && !refuse) begin
          state_next = vsc_pkg::ST_WAIT;
        end
      end
      vsc_pkg::ST_WAIT: begin
        if (fall) begin
          state_next = vsc_pkg::ST_SEND;
        end
      end
      vsc_pkg::ST_SEND: begin
        if (fall) begin
          state_next = vsc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = vsc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= vsc_pkg::ST_IDLE;
      div_reg   <= 3'h0;
      lclk_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      div_reg   <= div_wrap ? 3'h0 : div_reg + 3'h1;
      lclk_reg  <= div_wrap ? ~lclk_reg : lclk_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_reg  <= 1'b0;
      app_reg     <= 1'b0;
      idx_reg     <= 6'h00;
      arg_reg     <= 32'h0;
      len_reg     <= 16'h0000;
      refused_reg <= 1'b0;
    end else begin
      refused_reg <= accept & refuse;
      if (accept && !refuse) begin
        app_reg <= req_app;
        idx_reg <= req_index;
        arg_reg <= req_arg;
        len_reg <= len_pad;
      end
      if (fall) begin
        strobe_reg <= state_reg == vsc_pkg::ST_WAIT;
      end
    end
  end

  // Resume sequence tracking
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_ok_reg  <= 1'b0;
      resumed_reg <= 1'b0;
      rec_reg     <= 1'b0;
    end else if (accept && !refuse && sess) begin
      dir_ok_reg  <= (fn == vsc_pkg::FN_UPDATE_DIR) ? 1'b1 :
                     (fn == vsc_pkg::FN_RESUME || fn == vsc_pkg::FN_SUSPEND) ? 1'b0 : dir_ok_reg; // RULE_12
      resumed_reg <= (fn == vsc_pkg::FN_RESUME) ? 1'b1 : (fn == vsc_pkg::FN_START_REC) ? 1'b0 : resumed_reg;
      rec_reg     <= (fn == vsc_pkg::FN_START_REC) ? 1'b1 : (fn == vsc_pkg::FN_SUSPEND) ? 1'b0 : rec_reg;
    end
  end

  assign req_ready   = state_reg == vsc_pkg::ST_IDLE;
  assign req_refused = refused_reg;
  assign link.lclk   = lclk_reg;
  assign link.strobe = strobe_reg;
  assign link.app    = app_reg;
  assign link.index  = idx_reg;
  assign link.arg    = arg_reg;
  assign link.len    = len_reg;
endmodule : vsc_host_end

// ---- testbench/vsc_link_chk.sv ----
// Assertions on the command link and the card's session outputs
module vsc_link_chk (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        lclk,
  input wire logic        strobe,
  input wire logic        app,
  input wire logic [5:0]  index,
  input wire logic [31:0] arg,
  input wire logic        recording,
  input wire logic        suspended,
  input wire logic [31:0] resume_address,
  input wire logic [7:0]  dir_slots,
  input wire logic [3:0]  au_assigned
);
  logic       lclk_reg;
  logic [2:0] slot_reg;
  wire        take     = strobe & lclk & ~lclk_reg;
  wire        sess     = take & ~app & (index == 6'h14);
  wire        susp     = sess & (arg[3:0] == 4'h3);
  wire        std_term = ~app & (index == 6'h33 | index == 6'h38 | index[5:2] == 4'hf);
  wire        app_term = app & ((index >= 6'h01 & index <= 6'h0c) | index == 6'h11 | index == 6'h18
                         | index == 6'h1b | (index >= 6'h13 & index <= 6'h15) | (index >= 6'h1d & index <= 6'h25)
                         | (index >= 6'h27 & index <= 6'h2a) | index == 6'h32 | (index >= 6'h34 & index <= 6'h36)
                         | index[5:3] == 3'h7);
  wire        wr_cmd   = ~app & (index == 6'h18 | index == 6'h19 | index == 6'h32 | index == 6'h39
                         | (index >= 6'h22 & index <= 6'h25));
  wire        own_blk  = suspended & (resume_address != 32'h0) & (arg[31:13] == resume_address[31:13]);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Link clock edge finder and slot capture
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lclk_reg <= 1'b0;
      slot_reg <= 3'h0;
    end else begin
      lclk_reg <= lclk;
      slot_reg <= take ? arg[6:4] : slot_reg;
    end
  end

  AST_STD_TERM: assert property (take & std_term |-> ##10 !recording)
    else $error("recording kept after terminating command");
  AST_APP_TERM: assert property (take & app_term |-> ##10 !recording)
    else $error("recording kept after terminating app command");
  AST_TERM_FREES: assert property (take & (std_term | app_term) |-> ##10 au_assigned == 4'h0)
    else $error("blocks kept after terminating command");
  AST_SUSP_SLOTS: assert property (susp & recording |-> ##10 dir_slots == 8'h00 && !recording)
    else $error("slots kept after suspend");
  AST_SUSP_CHUNK: assert property (susp & recording |-> ##10 resume_address[9:0] == 10'h000)
    else $error("resume address not on chunk start");
  AST_SUSP_IDLE: assert property (susp & au_assigned == 4'h0 |=> $stable(resume_address)[*8])
    else $error("resume address changed by idle suspend");
  AST_KEEP_REC: assert property (sess & recording & (arg[3:0] == 4'h1 | arg[3:0] == 4'h2 | arg[3:0] == 4'h6)
    |=> recording[*8])
    else $error("directory update ended recording");
  AST_SLOT_SET: assert property (sess & arg[3:0] == 4'h1 |-> ##10 dir_slots[slot_reg])
    else $error("slot not assigned");
  AST_SLOT_FREE: assert property (sess & arg[3:0] == 4'h6 |-> ##10 !dir_slots[slot_reg])
    else $error("slot not released");
  AST_SUSP_WRITE: assert property (take & wr_cmd & own_blk |-> ##10 resume_address == 32'h0)
    else $error("resume address kept after write to suspended block");

  cover property (susp & recording);
  cover property (take & app_term);
  cover property (take & wr_cmd & own_blk);
endmodule : vsc_link_chk

// ---- testbench/tb.sv ----
// Self-checking bench joining the host and card ends
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] BASE = 32'h0001_0000;
  logic        sys_clk;
  logic        rst_n;
  logic        req_valid;
  logic        req_ready;
  logic        req_app;
  logic [5:0]  req_index;
  logic [31:0] req_arg;
  logic [15:0] req_len;
  logic        resume_address_zero;
  logic        req_refused;
  logic [31:0] saved;
  logic        recording;
  logic        su_timing_broken;
  logic        perf_dropped;
  logic        suspended;
  logic [31:0] resume_address;
  logic [7:0]  dir_slots;
  logic [3:0]  au_assigned;
  logic        refused;
  int          miscompares;
  int          checked;
  int          cycles;

  vsc_link_if link_bus ();
  vsc_host_end u_vsc_host_end (.sys_clk(sys_clk), .rst_n(rst_n), .link(link_bus), .req_valid(req_valid),
    .req_ready(req_ready), .req_app(req_app), .req_index(req_index), .req_arg(req_arg), .req_len(req_len),
    .resume_address_zero(resume_address_zero), .req_refused(req_refused));
  vsc_card_end u_vsc_card_end (.sys_clk(sys_clk), .rst_n(rst_n), .link(link_bus), .saved_resume_address(saved),
    .recording(recording), .su_timing_broken(su_timing_broken), .perf_dropped(perf_dropped),
    .suspended(suspended), .resume_address(resume_address), .dir_slots(dir_slots), .au_assigned(au_assigned));
  vsc_link_chk u_vsc_link_chk (.sys_clk(sys_clk), .rst_n(rst_n), .lclk(link_bus.lclk),
    .strobe(link_bus.strobe), .app(link_bus.app), .index(link_bus.index), .arg(link_bus.arg),
    .recording(recording), .suspended(suspended), .resume_address(resume_address), .dir_slots(dir_slots),
    .au_assigned(au_assigned));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", name, exp, got);
      miscompares++;
    end
  endtask : chk

  task automatic final_report();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic do_reset(input logic [31:0] nv);
    @(posedge sys_clk);
    saved <= nv;
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(negedge sys_clk);
  endtask : do_reset

  task automatic wait_ready();
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    if (req_ready !== 1'b1) chk("req_ready", 32'h1, 32'(req_ready));
  endtask : wait_ready

  task automatic send(input logic app, input logic [5:0] idx, input logic [31:0] arg, input logic [15:0] len);
    wait_ready();
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_app <= app;
    req_index <= idx;
    req_arg <= arg;
    req_len <= len;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    @(negedge sys_clk);
    refused = req_refused;
    @(negedge sys_clk);
    refused = refused | req_refused;
    wait_ready();
    repeat (8) @(negedge sys_clk);
  endtask : send

  task automatic cmd20(input logic [3:0] fn, input logic [2:0] slot, input logic [31:0] base);
    send(1'b0, 6'h14, base | 32'({slot, fn}), 16'h0001);
  endtask : cmd20

  // Update slot 0, free blocks at BASE, start recording
  task automatic setup(input logic [3:0] n);
    cmd20(4'h1, 3'h0, 32'h0);
    cmd20(4'h5, 3'(n - 4'h1), BASE);
    cmd20(4'h0, 3'h0, 32'h0);
    chk("recording", 32'h1, 32'(recording));
    chk("au_assigned", 32'(n), 32'(au_assigned));
  endtask : setup

  task automatic t_term();
    logic [6:0] tbl [25] = '{7'h33, 7'h38, 7'h3c, 7'h3f, 7'h41, 7'h4c, 7'h51, 7'h53, 7'h55, 7'h58, 7'h5b,
      7'h5d, 7'h65, 7'h67, 7'h6a, 7'h72, 7'h74, 7'h76, 7'h78, 7'h7f, 7'h4d, 7'h52, 7'h66, 7'h73, 7'h77};
    for (int k = 0; k < 25; k++) begin
      do_reset(32'h0);
      setup(4'h1);
      send(tbl[k][6], tbl[k][5:0], 32'h0, 16'h0001);
      chk("recording", 32'(k >= 20), 32'(recording));
      chk("au_assigned", 32'(k >= 20), 32'(au_assigned));
    end
  endtask : t_term

  task automatic t_slots();
    do_reset(32'h0);
    setup(4'h1);
    for (int s = 1; s < 8; s++) cmd20(4'h1, 3'(s), 32'h0);
    chk("dir_slots", 32'hff, 32'(dir_slots));
    cmd20(4'h2, 3'h0, 32'h0);
    cmd20(4'h6, 3'h3, 32'h0);
    chk("dir_slots", 32'hf7, 32'(dir_slots));
    chk("recording", 32'h1, 32'(recording));
    send(1'b0, 6'h19, BASE, 16'h0200);
    chk("su_timing_broken", 32'h0, 32'(su_timing_broken));
  endtask : t_slots

  task automatic t_timing();
    do_reset(32'h0);
    setup(4'h1);
    send(1'b0, 6'h39, BASE, 16'h0400);
    chk("su_timing_broken", 32'h0, 32'(su_timing_broken));
    send(1'b0, 6'h32, BASE + 32'h400, 16'h0200);
    chk("su_timing_broken", 32'h1, 32'(su_timing_broken));
    chk("recording", 32'h1, 32'(recording));
    send(1'b0, 6'h39, BASE + 32'h1000, 16'h0400);
    chk("recording", 32'h0, 32'(recording));
    do_reset(32'h0);
    setup(4'h1);
    send(1'b0, 6'h39, BASE + 32'h0, 16'h0200);
    chk("su_timing_broken", 32'h1, 32'(su_timing_broken));
  endtask : t_timing

  task automatic t_cross();
    do_reset(32'h0);
    setup(4'h2);
    send(1'b0, 6'h19, BASE, 16'h2400);
    chk("perf_dropped", 32'h0, 32'(perf_dropped));
    chk("su_timing_broken", 32'h0, 32'(su_timing_broken));
    send(1'b0, 6'h19, BASE + 32'h2400, 16'h2000);
    chk("perf_dropped", 32'h1, 32'(perf_dropped));
  endtask : t_cross

  task automatic t_suspend();
    do_reset(32'h0);
    setup(4'h2);
    send(1'b0, 6'h19, BASE, 16'h0400);
    cmd20(4'h3, 3'h0, 32'h0);
    chk("dir_slots", 32'h0, 32'(dir_slots));
    chk("resume_address", BASE + 32'h400, resume_address);
    chk("suspended", 32'h1, 32'(suspended));
    cmd20(4'h4, 3'h0, 32'h0);
    chk("req_refused", 32'h1, 32'(refused));
    cmd20(4'h1, 3'h0, 32'h0);
    cmd20(4'h4, 3'h0, 32'h0);
    chk("req_refused", 32'h0, 32'(refused));
    send(1'b0, 6'h19, BASE + 32'h400, 16'h0400);
    chk("req_refused", 32'h1, 32'(refused));
    cmd20(4'h0, 3'h0, 32'h0);
    send(1'b0, 6'h19, BASE + 32'h400, 16'h0400);
    chk("recording", 32'h1, 32'(recording));
  endtask : t_suspend

  task automatic t_partial();
    do_reset(32'h0);
    setup(4'h2);
    send(1'b0, 6'h32, BASE, 16'h0200);
    cmd20(4'h3, 3'h0, 32'h0);
    chk("resume_address", 32'h0, resume_address);
    chk("au_assigned", 32'h0, 32'(au_assigned));
    @(posedge sys_clk);
    resume_address_zero <= 1'b1;
    cmd20(4'h1, 3'h0, 32'h0);
    cmd20(4'h4, 3'h0, 32'h0);
    chk("req_refused", 32'h1, 32'(refused));
    @(posedge sys_clk);
    resume_address_zero <= 1'b0;
  endtask : t_partial

  task automatic t_power();
    do_reset(BASE + 32'h400);
    chk("resume_address", BASE + 32'h400, resume_address);
    chk("suspended", 32'h1, 32'(suspended));
    cmd20(4'h3, 3'h0, 32'h0);
    chk("resume_address", BASE + 32'h400, resume_address);
    send(1'b0, 6'h18, BASE + 32'h800, 16'h0001);
    chk("resume_address", 32'h0, resume_address);
  endtask : t_power

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      final_report();
    end
  end

  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_app = 1'b0;
    req_index = 6'h00;
    req_arg = 32'h0;
    req_len = 16'h0;
    resume_address_zero = 1'b0;
    saved = 32'h0;
    miscompares = 0;
    checked = 0;
    cycles = 0;
    t_term();
    t_slots();
    t_timing();
    t_cross();
    t_suspend();
    t_partial();
    t_power();
    final_report();
  end
endmodule : tb
